// ### pkg/tmr_pkg.sv
// Register map, field positions and reset values of the cascadable timer pair
package tmr_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          CNT_W           = 16;
    // Word offsets (byte address = 4 * index)
    localparam logic [3:0]  IDX_CTRL0       = 4'h0;
    localparam logic [3:0]  IDX_RELOAD0     = 4'h1;
    localparam logic [3:0]  IDX_COUNT0      = 4'h2;
    localparam logic [3:0]  IDX_CTRL1       = 4'h3;
    localparam logic [3:0]  IDX_RELOAD1     = 4'h4;
    localparam logic [3:0]  IDX_COUNT1      = 4'h5;
    localparam logic [3:0]  IDX_IRQ_STATUS  = 4'h6;
    localparam logic [3:0]  IDX_IRQ_MASK    = 4'h7;
    localparam logic [3:0]  IDX_PORT_DIR    = 4'h8;
    // Control register fields
    localparam int          CTRL_START      = 0;
    localparam int          CTRL_MODE_LO    = 1;
    localparam int          CTRL_PULSE_EN   = 3;
    localparam int          CTRL_TRIG_SEL   = 4;
    localparam int          CTRL_EDGE_RISE  = 5;
    localparam int          CTRL_SRC_LO     = 6;
    localparam int          CTRL_W          = 8;
    // Mode field
    localparam logic [1:0]  MODE_PERIODIC   = 2'h0;
    localparam logic [1:0]  MODE_EVENT      = 2'h1;
    localparam logic [1:0]  MODE_ONESHOT    = 2'h2;
    // Count source field
    localparam logic [1:0]  SRC_UNDIV       = 2'h0;
    localparam logic [1:0]  SRC_DIV8        = 2'h1;
    localparam logic [1:0]  SRC_DIV32       = 2'h2;
    localparam int          DIV8_N          = 8;
    localparam int          DIV32_N         = 32;
    // Reset values
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [15:0] RELOAD_RST      = 16'hFFFF;
    localparam logic [31:0] UNMAPPED_RD     = 32'h0000_0000;
endpackage

// ### rtl/tmr_prescaler.sv
// Free-running divider giving one-cycle ticks at the selectable count rates
`timescale 1ns/10ps
module tmr_prescaler #(
    parameter int DIV_A = tmr_pkg::DIV8_N,
    parameter int DIV_B = tmr_pkg::DIV32_N
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // Ticks
    output logic      tick_a,
    output logic      tick_b
);
    logic [5:0] div_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            div_r <= 6'h00;
        end else begin
            div_r <= div_r + 6'h01;
        end
    end

    assign tick_a = (div_r[2:0] == 3'(DIV_A - 1));
    assign tick_b = (div_r[4:0] == 5'(DIV_B - 1));
endmodule

// ### rtl/tmr_stage.sv
// One 16-bit down-counting timer stage with reload, modes and pulse output
`timescale 1ns/10ps
module tmr_stage #(
    parameter int CNT_W = tmr_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RST,
    // Configuration
    input  wire logic [7:0]       ctrl,
    input  wire logic [CNT_W-1:0] reload,
    input  wire logic             reload_wr,
    // Count events
    input  wire logic             src_tick,
    input  wire logic             event_tick,
    input  wire logic             trig_in,
    input  wire logic             ext_rise,
    input  wire logic             ext_fall,
    // Results
    output logic [CNT_W-1:0]      count,
    output logic                  underflow,
    output logic                  pulse_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} stage_state_t;

    stage_state_t     state_r;
    logic [CNT_W-1:0] cnt_r;
    logic             pulse_r;
    logic             start;
    logic [1:0]       mode;
    logic             step;
    logic             ext_edge;
    logic             os_done;

    assign start    = ctrl[tmr_pkg::CTRL_START];
    assign mode     = ctrl[tmr_pkg::CTRL_MODE_LO +: 2];
    assign ext_edge = ctrl[tmr_pkg::CTRL_EDGE_RISE] ? ext_rise : ext_fall;
    assign step     = (mode == tmr_pkg::MODE_EVENT) ? event_tick : src_tick;
    assign os_done  = (state_r == ST_RUN) && step && (cnt_r == '0);

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= ST_IDLE;
        end else if (!start) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (mode != tmr_pkg::MODE_ONESHOT) begin
                        state_r <= ST_RUN;
                    end else if (ctrl[tmr_pkg::CTRL_TRIG_SEL]) begin
                        state_r <= ST_ARMED;
                    end else if (trig_in) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_ARMED: begin
                    if (ext_edge) begin
                        state_r <= ST_RUN;
                    end
                end
                default: begin
                    if (mode == tmr_pkg::MODE_ONESHOT && os_done) begin
                        state_r <= ctrl[tmr_pkg::CTRL_TRIG_SEL] ? ST_ARMED : ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_r <= tmr_pkg::RELOAD_RST;
        end else if (reload_wr && state_r != ST_RUN) begin
            cnt_r <= reload;
        end else if (state_r == ST_RUN && step) begin
            if (cnt_r == '0) begin
                cnt_r <= reload;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign underflow = (state_r == ST_RUN) && step && (cnt_r == '0) && start;
    assign count     = cnt_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            pulse_r <= 1'b0;
        end else if (!ctrl[tmr_pkg::CTRL_PULSE_EN] || !start) begin
            pulse_r <= 1'b0;
        end else if (mode == tmr_pkg::MODE_ONESHOT) begin
            if (os_done) begin
                pulse_r <= 1'b0;
            end else if (state_r == ST_RUN) begin
                pulse_r <= 1'b1;
            end else if (state_r == ST_IDLE && trig_in && !ctrl[tmr_pkg::CTRL_TRIG_SEL]) begin
                pulse_r <= 1'b1;
            end else if (state_r == ST_ARMED && ext_edge) begin
                pulse_r <= 1'b1;
            end
        end else if (underflow) begin
            pulse_r <= ~pulse_r;
        end
    end

    assign pulse_out = pulse_r;
endmodule

// ### rtl/cascadable_timer_pair.sv
// Two cascadable 16-bit timers with Avalon-MM registers and an interrupt
`timescale 1ns/10ps
module cascadable_timer_pair (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // First timer pin
    input  wire logic        FIRST_TIMER_IO_PIN_IN,
    output logic             FIRST_TIMER_IO_PIN_OUT,
    output logic             FIRST_TIMER_IO_PIN_OE_N,
    // Second timer pin
    input  wire logic        SECOND_TIMER_IO_PIN_IN,
    output logic             SECOND_TIMER_IO_PIN_OUT,
    output logic             SECOND_TIMER_IO_PIN_OE_N,
    // Interrupt
    output logic             IRQ
);
    localparam int N = 2;

    logic [7:0]  ctrl_r   [N];
    logic [15:0] reload_r [N];
    logic [N-1:0] reload_wr;
    logic [15:0] count    [N];
    logic [N-1:0] uf;
    logic [N-1:0] pulse;
    logic [N-1:0] src_tick;
    logic [N-1:0] ev_tick;
    logic [N-1:0] pin_in;
    logic [N-1:0] pin_d_r;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] dir_r;
    logic [N-1:0] status_r;
    logic [N-1:0] mask_r;
    logic [N-1:0] pin_out_r;
    logic [N-1:0] pin_oe_n_r;
    logic         irq_r;
    logic [31:0]  rdata_r;
    logic [31:0]  rdata_nxt;
    logic         ack_r;
    logic         wait_r;
    logic         tick8;
    logic         tick32;
    logic         wr_go;
    logic         rd_go;
    logic [31:0]  wmask;

    // Byte enables expand to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Source select shared by both stages
    function automatic logic sel_src(input logic [1:0] sel, input logic t8, input logic t32);
        if (sel == tmr_pkg::SRC_UNDIV) begin
            sel_src = 1'b1;
        end else if (sel == tmr_pkg::SRC_DIV8) begin
            sel_src = t8;
        end else if (sel == tmr_pkg::SRC_DIV32) begin
            sel_src = t32;
        end else begin
            sel_src = 1'b0;
        end
    endfunction

    // A write lands only on the edge that completes the transfer
    assign wr_go = AVS_WRITE && ack_r;
    assign rd_go = AVS_READ && !ack_r;
    assign wmask = be_mask(AVS_BYTEENABLE);

    assign pin_in = {SECOND_TIMER_IO_PIN_IN, FIRST_TIMER_IO_PIN_IN};

    tmr_prescaler u_pre (
        .CLK    (CLK),
        .RST    (RST),
        .tick_a (tick8),
        .tick_b (tick32)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            // Idle pin level is high, so no false edge follows reset
            pin_d_r <= '1;
        end else begin
            pin_d_r <= pin_in;
        end
    end

    assign rise = pin_in & ~pin_d_r;
    assign fall = ~pin_in & pin_d_r;

    assign src_tick[0] = sel_src(ctrl_r[0][tmr_pkg::CTRL_SRC_LO +: 2], tick8, tick32);
    assign src_tick[1] = sel_src(ctrl_r[1][tmr_pkg::CTRL_SRC_LO +: 2], tick8, tick32);
    assign ev_tick[0]  = fall[0];
    assign ev_tick[1]  = uf[0];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_stage
            tmr_stage u_stage (
                .CLK        (CLK),
                .RST        (RST),
                .ctrl       (ctrl_r[g]),
                .reload     (reload_r[g]),
                .reload_wr  (reload_wr[g]),
                .src_tick   (src_tick[g]),
                .event_tick (ev_tick[g]),
                .trig_in    ((g == 1) ? uf[0] : 1'b0),
                .ext_rise   (rise[0]),
                .ext_fall   (fall[0]),
                .count      (count[g]),
                .underflow  (uf[g]),
                .pulse_out  (pulse[g])
            );
        end
    endgenerate

    // Control registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_r[0] <= tmr_pkg::CTRL_RST;
            ctrl_r[1] <= tmr_pkg::CTRL_RST;
        end else if (wr_go) begin
            if (AVS_ADDRESS == tmr_pkg::IDX_CTRL0) begin
                ctrl_r[0] <= (ctrl_r[0] & ~wmask[7:0]) | (AVS_WRITEDATA[7:0] & wmask[7:0]);
            end else if (AVS_ADDRESS == tmr_pkg::IDX_CTRL1) begin
                ctrl_r[1] <= (ctrl_r[1] & ~wmask[7:0]) | (AVS_WRITEDATA[7:0] & wmask[7:0]);
            end
        end
    end

    // Reload registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            reload_r[0] <= tmr_pkg::RELOAD_RST;
            reload_r[1] <= tmr_pkg::RELOAD_RST;
        end else if (wr_go) begin
            if (AVS_ADDRESS == tmr_pkg::IDX_RELOAD0) begin
                reload_r[0] <= (reload_r[0] & ~wmask[15:0])
                             | (AVS_WRITEDATA[15:0] & wmask[15:0]);
            end else if (AVS_ADDRESS == tmr_pkg::IDX_RELOAD1) begin
                reload_r[1] <= (reload_r[1] & ~wmask[15:0])
                             | (AVS_WRITEDATA[15:0] & wmask[15:0]);
            end
        end
    end

    // Strobe that lets an idle stage take the new reload value
    always_ff @(posedge CLK) begin
        if (RST) begin
            reload_wr <= '0;
        end else begin
            reload_wr[0] <= wr_go && (AVS_ADDRESS == tmr_pkg::IDX_RELOAD0);
            reload_wr[1] <= wr_go && (AVS_ADDRESS == tmr_pkg::IDX_RELOAD1);
        end
    end

    // Interrupt mask
    always_ff @(posedge CLK) begin
        if (RST) begin
            mask_r <= '0;
        end else if (wr_go && AVS_ADDRESS == tmr_pkg::IDX_IRQ_MASK) begin
            mask_r <= (mask_r & ~wmask[N-1:0]) | (AVS_WRITEDATA[N-1:0] & wmask[N-1:0]);
        end
    end

    // Port direction, bit 0 first pin, bit 1 second pin
    always_ff @(posedge CLK) begin
        if (RST) begin
            dir_r <= '0;
        end else if (wr_go && AVS_ADDRESS == tmr_pkg::IDX_PORT_DIR) begin
            dir_r <= (dir_r & ~wmask[N-1:0]) | (AVS_WRITEDATA[N-1:0] & wmask[N-1:0]);
        end
    end

    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            status_r <= '0;
        end else begin
            if (wr_go && AVS_ADDRESS == tmr_pkg::IDX_IRQ_STATUS) begin
                status_r <= (status_r & ~(AVS_WRITEDATA[N-1:0] & wmask[N-1:0])) | uf;
            end else begin
                status_r <= status_r | uf;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    // Pin drivers
    always_ff @(posedge CLK) begin
        if (RST) begin
            pin_out_r  <= '0;
            pin_oe_n_r <= '1;
        end else begin
            pin_out_r  <= pulse;
            pin_oe_n_r <= ~(dir_r & {ctrl_r[1][tmr_pkg::CTRL_PULSE_EN],
                                     ctrl_r[0][tmr_pkg::CTRL_PULSE_EN]});
        end
    end

    // Read decode of the addressed register
    always_comb begin
        rdata_nxt = tmr_pkg::UNMAPPED_RD;
        if (AVS_ADDRESS == tmr_pkg::IDX_CTRL0) begin
            rdata_nxt = {24'h00_0000, ctrl_r[0]};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_CTRL1) begin
            rdata_nxt = {24'h00_0000, ctrl_r[1]};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_RELOAD0) begin
            rdata_nxt = {16'h0000, reload_r[0]};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_RELOAD1) begin
            rdata_nxt = {16'h0000, reload_r[1]};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_COUNT0) begin
            rdata_nxt = {16'h0000, count[0]};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_COUNT1) begin
            rdata_nxt = {16'h0000, count[1]};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_IRQ_STATUS) begin
            rdata_nxt = {30'h0000_0000, status_r};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_IRQ_MASK) begin
            rdata_nxt = {30'h0000_0000, mask_r};
        end else if (AVS_ADDRESS == tmr_pkg::IDX_PORT_DIR) begin
            rdata_nxt = {30'h0000_0000, dir_r};
        end
    end

    // Bus answer: one wait cycle, then waitrequest low for one cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_r  <= 1'b0;
            wait_r <= 1'b1;
        end else begin
            ack_r  <= (AVS_READ || AVS_WRITE) && !ack_r;
            wait_r <= !((AVS_READ || AVS_WRITE) && !ack_r);
        end
    end

    // Read data is captured on the first edge that sees the request
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r <= tmr_pkg::UNMAPPED_RD;
        end else if (rd_go) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign AVS_READDATA             = rdata_r;
    assign AVS_WAITREQUEST          = wait_r;
    assign FIRST_TIMER_IO_PIN_OUT   = pin_out_r[0];
    assign SECOND_TIMER_IO_PIN_OUT  = pin_out_r[1];
    assign FIRST_TIMER_IO_PIN_OE_N  = pin_oe_n_r[0];
    assign SECOND_TIMER_IO_PIN_OE_N = pin_oe_n_r[1];
    assign IRQ                      = irq_r;
endmodule

// ### bench/cascadable_timer_pair_assertions.sv
// Port-level checker for the cascadable timer pair, bound to its top module
`timescale 1ns/10ps
module cascadable_timer_pair_checker (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Register bus
    input wire logic [3:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // Timer pins and interrupt
    input wire logic        FIRST_TIMER_IO_PIN_IN,
    input wire logic        FIRST_TIMER_IO_PIN_OUT,
    input wire logic        FIRST_TIMER_IO_PIN_OE_N,
    input wire logic        SECOND_TIMER_IO_PIN_IN,
    input wire logic        SECOND_TIMER_IO_PIN_OUT,
    input wire logic        SECOND_TIMER_IO_PIN_OE_N,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_answer;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");
    property p_one_low;
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
    endproperty
    a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
    property p_no_spurious;
        !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
    property p_unmapped;
        !AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS > 4'h8 |-> AVS_READDATA == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_upper_zero;
        !AVS_WAITREQUEST && AVS_READ |-> AVS_READDATA[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_rdata_stable;
        $changed(AVS_READDATA) |-> $past(AVS_READ && AVS_WAITREQUEST);
    endproperty
    a_rdata_stable: assert property (p_rdata_stable) else $error("read data moved");
    property p_oe_first;
        $changed(FIRST_TIMER_IO_PIN_OE_N) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2);
    endproperty
    a_oe_first: assert property (p_oe_first) else $error("first enable moved");
    property p_oe_second;
        $changed(SECOND_TIMER_IO_PIN_OE_N) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2);
    endproperty
    a_oe_second: assert property (p_oe_second) else $error("second enable moved");
    property p_irq_sticky;
        $fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2);
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell by itself");

    c_irq: cover property ($rose(IRQ));
    c_pulse: cover property ($rose(SECOND_TIMER_IO_PIN_OUT));
    c_unmapped: cover property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS > 4'h8);
endmodule

bind cascadable_timer_pair cascadable_timer_pair_checker cascadable_timer_pair_checker_i (
    .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .FIRST_TIMER_IO_PIN_IN(FIRST_TIMER_IO_PIN_IN), .FIRST_TIMER_IO_PIN_OUT(FIRST_TIMER_IO_PIN_OUT),
    .FIRST_TIMER_IO_PIN_OE_N(FIRST_TIMER_IO_PIN_OE_N),
    .SECOND_TIMER_IO_PIN_IN(SECOND_TIMER_IO_PIN_IN),
    .SECOND_TIMER_IO_PIN_OUT(SECOND_TIMER_IO_PIN_OUT),
    .SECOND_TIMER_IO_PIN_OE_N(SECOND_TIMER_IO_PIN_OE_N), .IRQ(IRQ));

// ### bench/timer_pin_partner.sv
// Trigger source and pulled-up load on the two timer pins
`timescale 1ns/10ps
module timer_pin_partner (
    // Clock
    input  wire logic CLK,
    // Design side of the pins
    input  wire logic first_out,
    input  wire logic first_oe_n,
    input  wire logic second_out,
    input  wire logic second_oe_n,
    // Resolved pin levels
    output logic      first_level,
    output logic      second_level
);
    logic src_r = 1'b1;
    // released pin follows source or pull-up
    assign first_level  = first_oe_n ? src_r : first_out;
    assign second_level = second_oe_n ? 1'b1 : second_out;

    task give_edge(input logic lvl);
        @(posedge CLK);
        src_r <= lvl;
        repeat (3) @(posedge CLK);
    endtask
endmodule

// ### bench/cascadable_timer_pair_tb_top.sv
// Self-checking bench for the cascadable timer pair
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module cascadable_timer_pair_tb_top;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic        wq;
    logic        f_out, f_oe_n, s_out, s_oe_n, f_lvl, s_lvl, irq;
    logic [31:0] v;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          hi, per;
    logic [3:0]  regs [7] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9};
    logic [31:0] rstv [7] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0000,
                              32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    always #5 CLK = ~CLK;

    cascadable_timer_pair cascadable_timer_pair_i (
        .CLK(CLK), .RST(RST), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wq), .FIRST_TIMER_IO_PIN_IN(f_lvl), .FIRST_TIMER_IO_PIN_OUT(f_out),
        .FIRST_TIMER_IO_PIN_OE_N(f_oe_n), .SECOND_TIMER_IO_PIN_IN(s_lvl),
        .SECOND_TIMER_IO_PIN_OUT(s_out), .SECOND_TIMER_IO_PIN_OE_N(s_oe_n), .IRQ(irq));

    timer_pin_partner timer_pin_partner_i (
        .CLK(CLK), .first_out(f_out), .first_oe_n(f_oe_n), .second_out(s_out),
        .second_oe_n(s_oe_n), .first_level(f_lvl), .second_level(s_lvl));

    task report_and_stop;
        $display("compares=%0d errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // Holds the request until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        addr <= a;
        wdata <= d;
        if (w) wr <= 1'b1;
        else rd <= 1'b1;
        // Only waitrequest seen low or the bench timeout ends this wait
        do begin
            @(posedge CLK);
            #1;
        end while (wq !== 1'b0);
        @(posedge CLK);
        v = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(v, e)
    endtask

    // Width of a high phase and distance between rises on one pin
    task pulse_gap(input logic second, output int h, output int p);
        int n;
        n = 0;
        h = 0;
        p = 0;
        while ((second ? s_lvl : f_lvl) !== 1'b0 && n < 300) begin @(posedge CLK); #1; n++; end
        while ((second ? s_lvl : f_lvl) !== 1'b1 && n < 300) begin @(posedge CLK); #1; n++; end
        while ((second ? s_lvl : f_lvl) === 1'b1 && n < 300) begin @(posedge CLK); #1; n++; h++; end
        p = h;
        while ((second ? s_lvl : f_lvl) === 1'b0 && n < 300) begin @(posedge CLK); #1; n++; p++; end
    endtask

    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 7; i++) rd_chk(regs[i], rstv[i]);
        $display("test reset_values done");
        wr_reg(4'h1, 32'h0000_0004);
        wr_reg(4'h0, 32'h0000_0001);
        repeat (20) @(posedge CLK);
        bus(1'b0, 4'h2, 32'h0000_0000);
        per = v;
        bus(1'b0, 4'h2, 32'h0000_0000);
        `CHK(v <= 32'h0000_0004 && v != per, 1'b1)
        rd_chk(4'h6, 32'h0000_0001);
        wr_reg(4'h7, 32'h0000_0001);
        repeat (3) @(posedge CLK);
        `CHK(irq, 1'b1)
        wr_reg(4'h0, 32'h0000_0000);
        repeat (10) @(posedge CLK);
        `CHK(irq, 1'b1)
        wr_reg(4'h6, 32'h0000_0001);
        repeat (3) @(posedge CLK);
        `CHK(irq, 1'b0)
        $display("test periodic_irq done");
        wr_reg(4'h4, 32'h0000_0002);
        wr_reg(4'h3, 32'h0000_0003);
        wr_reg(4'h1, 32'h0000_0001);
        repeat (20) @(posedge CLK);
        rd_chk(4'h5, 32'h0000_0002);
        wr_reg(4'h0, 32'h0000_0001);
        repeat (40) @(posedge CLK);
        rd_chk(4'h6, 32'h0000_0003);
        wr_reg(4'h0, 32'h0000_0000);
        wr_reg(4'h3, 32'h0000_0000);
        wr_reg(4'h6, 32'h0000_0003);
        $display("test cascade done");
        wr_reg(4'h4, 32'h0000_0003);
        wr_reg(4'h1, 32'h0000_0009);
        wr_reg(4'h3, 32'h0000_000D);
        wr_reg(4'h8, 32'h0000_0002);
        wr_reg(4'h0, 32'h0000_0001);
        pulse_gap(1'b1, hi, per);
        `CHK(hi, 4)
        `CHK(per, 10)
        `CHK(s_oe_n, 1'b0)
        rd_chk(4'h6, 32'h0000_0003);
        wr_reg(4'h0, 32'h0000_0000);
        wr_reg(4'h3, 32'h0000_0000);
        wr_reg(4'h6, 32'h0000_0003);
        $display("test pwm done");
        wr_reg(4'h1, 32'h0000_0002);
        wr_reg(4'h8, 32'h0000_0001);
        wr_reg(4'h0, 32'h0000_0009);
        pulse_gap(1'b0, hi, per);
        `CHK(hi, 3)
        `CHK(per, 6)
        `CHK(f_oe_n, 1'b0)
        wr_reg(4'h0, 32'h0000_0049);
        pulse_gap(1'b0, hi, per);
        `CHK(hi, 24)
        `CHK(per, 48)
        wr_reg(4'h8, 32'h0000_0000);
        repeat (3) @(posedge CLK);
        `CHK(f_oe_n, 1'b1)
        wr_reg(4'h0, 32'h0000_0000);
        $display("test pulse_out done");
        wr_reg(4'h1, 32'h0000_0000);
        wr_reg(4'h6, 32'h0000_0003);
        wr_reg(4'h0, 32'h0000_0003);
        rd_chk(4'h6, 32'h0000_0000);
        timer_pin_partner_i.give_edge(1'b0);
        rd_chk(4'h6, 32'h0000_0001);
        wr_reg(4'h6, 32'h0000_0001);
        timer_pin_partner_i.give_edge(1'b1);
        rd_chk(4'h6, 32'h0000_0000);
        wr_reg(4'h0, 32'h0000_0000);
        $display("test event_pin done");
        wr_reg(4'h1, 32'h0000_0005);
        wr_reg(4'h0, 32'h0000_0035);
        timer_pin_partner_i.give_edge(1'b0);
        repeat (20) @(posedge CLK);
        rd_chk(4'h6, 32'h0000_0000);
        timer_pin_partner_i.give_edge(1'b1);
        repeat (15) @(posedge CLK);
        rd_chk(4'h6, 32'h0000_0001);
        $display("test ext_trigger done");
        report_and_stop();
    end
endmodule
